// ### ser_cfg.svh
// Register offsets, bit positions, reset values and event codes of the status block.
`ifndef SER_CFG_SVH
`define SER_CFG_SVH

`define ADDR_DEV_EN    8'h00
`define ADDR_SUM_EN    8'h04
`define ADDR_SRQ_EN    8'h08
`define ADDR_EVT_STAT  8'h0c
`define ADDR_STB       8'h10
`define ADDR_POLL      8'h14
`define ADDR_EVT_READ  8'h18
`define ADDR_EVT_CNT   8'h1c

`define DEV_EN_RST     8'hff
`define SUM_EN_RST     8'h00
`define SRQ_EN_RST     8'h00

`define BIT_POWER_ON   7
`define BIT_USER_REQ   6
`define BIT_CMD_ERR    5
`define BIT_EXEC_ERR   4
`define BIT_DEV_ERR    3
`define BIT_QUERY_ERR  2
`define BIT_OPC        0
`define STB_SUMMARY    6
`define STB_EVENT_SUM  5
`define STB_MSG_AVAIL  4

`define QUEUE_DEPTH    20
`define SEMICOLON      8'h3b
`define HSIZE_WORD     3'h2

`define CODE_EMPTY     10'h000
`define CODE_PENDING   10'h001
`define CODE_CMD_LO    10'h064
`define CODE_CMD_HI    10'h0b8
`define CODE_EXEC_LO   10'h0c8
`define CODE_CONFLICT  10'h0dd
`define CODE_EXEC_HI   10'h116
`define CODE_DEV_LO    10'h12c
`define CODE_DEV_HI    10'h13b
`define CODE_OVERFLOW  10'h15e
`define CODE_POWER_ON  10'h191
`define CODE_OPC       10'h192
`define CODE_USER_REQ  10'h193
`define CODE_QUERY_LO  10'h19a
`define CODE_QUERY_HI  10'h1b8
`define CODE_WARN_LO   10'h1f4
`define CODE_WARN_HI   10'h21c

`endif

// ### ser_pkg.sv
// Types shared by the status and event reporting block.
package ser_pkg;
    typedef logic [9:0] event_code_t;

    typedef struct packed {
        event_code_t code;
        logic [7:0]  detail;
    } event_entry_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } bus_phase_t;
endpackage

// ### event_classify.sv
// Maps an event code onto its one standard event status bit.
`timescale 1ns/1ps
`include "ser_cfg.svh"
module event_classify
    import ser_pkg::*;
(
    // Event code in
    input  wire event_code_t code,
    // One-hot status bit out, zero for codes that set none
    output logic [7:0]       bits
);
    always_comb begin
        bits = 8'h00;
        if (code >= `CODE_CMD_LO && code <= `CODE_CMD_HI) begin
            bits[`BIT_CMD_ERR] = 1'b1;
        end else if (code >= `CODE_EXEC_LO && code <= `CODE_EXEC_HI) begin
            bits[`BIT_EXEC_ERR] = 1'b1;
        end else if (code >= `CODE_DEV_LO && code <= `CODE_DEV_HI) begin
            bits[`BIT_DEV_ERR] = 1'b1;
        end else if (code == `CODE_POWER_ON) begin
            bits[`BIT_POWER_ON] = 1'b1;
        end else if (code == `CODE_OPC) begin
            bits[`BIT_OPC] = 1'b1;
        end else if (code == `CODE_USER_REQ) begin
            bits[`BIT_USER_REQ] = 1'b1;
        end else if (code >= `CODE_QUERY_LO && code <= `CODE_QUERY_HI) begin
            bits[`BIT_QUERY_ERR] = 1'b1;
        end else if (code >= `CODE_WARN_LO && code <= `CODE_WARN_HI) begin
            bits[`BIT_EXEC_ERR] = 1'b1;
        end
    end
endmodule

// ### event_queue.sv
// Event queue with overflow marking and release of entries on a status read.
`timescale 1ns/1ps
`include "ser_cfg.svh"
module event_queue
    import ser_pkg::*;
#(
    parameter int DEPTH = `QUEUE_DEPTH
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // Control
    input  wire logic                       push,
    input  wire event_entry_t               push_entry,
    input  wire logic                       release_all,
    input  wire logic                       pop,
    // State
    output event_entry_t                    head,
    output logic [$clog2(DEPTH+1)-1:0]      count,
    output logic [$clog2(DEPTH+1)-1:0]      released
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    if (DEPTH < 2 || DEPTH > 255) begin : g_bad_depth
        $error("event_queue DEPTH must lie in 2..255");
    end

    event_entry_t   mem [DEPTH];
    logic [PW-1:0]  head_ptr;
    logic [PW-1:0]  wr_idx;
    logic [CW-1:0]  drop;
    logic           full;
    event_entry_t   wr_entry;

    function automatic logic [PW-1:0] wrap(input logic [PW:0] v);
        wrap = (v >= (PW+1)'(DEPTH)) ? PW'(v - (PW+1)'(DEPTH)) : PW'(v);
    endfunction

    assign full     = (count == CW'(DEPTH));
    // A push into a full queue overwrites its last slot with the overflow marker.
    assign wr_idx   = full ? wrap({1'b0, head_ptr} + (PW+1)'(DEPTH - 1))
                           : wrap({1'b0, head_ptr} + (PW+1)'(count));
    assign wr_entry = full ? '{code: `CODE_OVERFLOW, detail: 8'h00} : push_entry;
    assign drop     = release_all ? released : (pop ? CW'(1) : CW'(0));
    assign head     = mem[head_ptr];

    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem[i] <= '0;
            end else if (push && wr_idx == PW'(i)) begin
                mem[i] <= wr_entry;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_ptr <= '0;
            count    <= '0;
            released <= '0;
        end else begin
            head_ptr <= wrap({1'b0, head_ptr} + (PW+1)'(drop));
            count    <= count - drop + CW'(push && !full);
            // Unread released entries are dropped; the rest become readable.
            released <= release_all ? count - released : released - CW'(pop);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_Q_BOUND: assert property (count <= CW'(DEPTH))
        else $error("event queue holds more than its depth");
    AST_Q_OVF: assert property (push && full |=> mem[$past(wr_idx)].code == `CODE_OVERFLOW)
        else $error("overflow marker missing in last slot");
endmodule

// ### status_event_reporting.sv
// Status byte, event status, enables, service request and event queue behind an AHB-Lite slave.
`timescale 1ns/1ps
`include "ser_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
module status_event_reporting
    import ser_pkg::*;
#(
    parameter int QUEUE_DEPTH = `QUEUE_DEPTH
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Event source
    input  wire logic        ev_valid,
    input  wire event_code_t ev_code,
    input  wire logic [7:0]  ev_detail,
    // Command message progress
    input  wire logic        msg_done,
    input  wire logic        settings_conflict,
    input  wire logic        outq_not_empty,
    // Service request toward the controller
    output logic             service_request
);
    localparam int CW = $clog2(QUEUE_DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0]    dev_en;
    logic [7:0]    sum_en;
    logic [7:0]    srq_en;
    logic [7:0]    next_dev_en;
    logic [7:0]    next_sum_en;
    logic [7:0]    next_srq_en;
    logic [7:0]    standard_event_status;
    logic [7:0]    stb_base;
    logic [7:0]    status_byte;
    logic          event_summary_bit;
    logic          message_available_bit;
    logic          master_summary_bit;
    logic          prev_master_summary;
    logic          request_service_bit;
    logic          conflict_pend;
    bus_phase_t    ap;
    bus_phase_t    dp;
    logic          rd;
    logic          wr;
    logic          esr_rd;
    logic          poll_rd;
    logic          evt_rd;
    logic          pop;
    logic          cand;
    logic          push;
    event_entry_t  push_entry;
    logic [7:0]    ev_bits_raw;
    logic [7:0]    ev_bits;
    event_entry_t  q_head;
    logic [CW-1:0] q_count;
    logic [CW-1:0] q_rel;
    logic [31:0]   rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // Zero wait states: read data is captured at the address phase edge.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ap.valid  = hsel && htrans[1] && hready && (hsize == `HSIZE_WORD);
    assign ap.write  = hwrite;
    assign ap.addr   = haddr[7:0];

    assign rd      = ap.valid && !ap.write;
    assign wr      = dp.valid && dp.write;
    assign esr_rd  = rd && ap.addr == `ADDR_EVT_STAT;
    assign poll_rd = rd && ap.addr == `ADDR_POLL;
    assign evt_rd  = rd && ap.addr == `ADDR_EVT_READ;
    assign pop     = evt_rd && q_rel != '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp <= '0;
        end else begin
            dp <= ap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable masks

    // A read right behind a write to the same mask sees the new value.
    assign next_dev_en = (wr && dp.addr == `ADDR_DEV_EN) ? hwdata[7:0] : dev_en;
    assign next_sum_en = (wr && dp.addr == `ADDR_SUM_EN) ? hwdata[7:0] : sum_en;
    assign next_srq_en = (wr && dp.addr == `ADDR_SRQ_EN) ? hwdata[7:0] : srq_en;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dev_en <= `DEV_EN_RST;
            sum_en <= `SUM_EN_RST;
            srq_en <= `SRQ_EN_RST;
        end else begin
            dev_en <= next_dev_en;
            sum_en <= next_sum_en;
            srq_en <= next_srq_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event intake

    event_classify u_classify (
        .code (push_entry.code),
        .bits (ev_bits_raw)
    );

    // A conflict event waits for a cycle free of source events.
    always_comb begin
        cand = ev_valid || conflict_pend;
        if (ev_valid) begin
            push_entry = '{code: ev_code, detail: ev_detail};
        end else begin
            push_entry = '{code: `CODE_CONFLICT, detail: 8'h00};
        end
    end

    assign ev_bits = ev_bits_raw & dev_en;
    assign push    = cand && (ev_bits != 8'h00);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conflict_pend <= 1'b0;
        end else if (msg_done && settings_conflict) begin
            conflict_pend <= 1'b1;
        end else if (!ev_valid) begin
            conflict_pend <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Standard event status

    // A new event in the same cycle as the clearing read survives it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            standard_event_status <= 8'h00;
        end else begin
            standard_event_status <= (esr_rd ? 8'h00 : standard_event_status) | (push ? ev_bits : 8'h00);
        end
    end

    event_queue #(
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .clk         (hclk),
        .rst_n       (hresetn),
        .push        (push),
        .push_entry  (push_entry),
        .release_all (esr_rd),
        .pop         (pop),
        .head        (q_head),
        .count       (q_count),
        .released    (q_rel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status byte and service request

    assign event_summary_bit     = (standard_event_status & sum_en) != 8'h00;
    assign message_available_bit = outq_not_empty;
    assign stb_base              = {2'b00, event_summary_bit, message_available_bit, 4'h0};
    assign master_summary_bit    = (stb_base & srq_en) != 8'h00;
    assign status_byte           = {1'b0, master_summary_bit, event_summary_bit, message_available_bit, 4'h0};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_master_summary <= 1'b0;
        end else begin
            prev_master_summary <= master_summary_bit;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            request_service_bit <= 1'b0;
        end else if (master_summary_bit && !prev_master_summary) begin
            request_service_bit <= 1'b1;
        end else if (poll_rd || !master_summary_bit) begin
            request_service_bit <= 1'b0;
        end
    end

    assign service_request = request_service_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        rd_word = 32'h0000_0000;
        case (ap.addr)
            `ADDR_DEV_EN:   rd_word[7:0] = next_dev_en;
            `ADDR_SUM_EN:   rd_word[7:0] = next_sum_en;
            `ADDR_SRQ_EN:   rd_word[7:0] = next_srq_en;
            `ADDR_EVT_STAT: rd_word[7:0] = standard_event_status;
            `ADDR_STB:      rd_word[7:0] = status_byte;
            `ADDR_POLL:     rd_word[7:0] = {1'b0, request_service_bit, event_summary_bit, message_available_bit, 4'h0};
            `ADDR_EVT_READ: begin
                if (q_rel != '0) begin
                    rd_word[9:0]   = q_head.code;
                    rd_word[23:16] = q_head.detail;
                    rd_word[31:24] = (q_head.detail != 8'h00) ? `SEMICOLON : 8'h00;
                end else begin
                    rd_word[9:0] = (q_count == '0) ? `CODE_EMPTY : `CODE_PENDING;
                end
            end
            `ADDR_EVT_CNT:  rd_word = 32'(q_count) | (32'(q_rel) << 8);
            default:        rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd) begin
            hrdata <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_summary_rise;
        master_summary_bit && !prev_master_summary;
    endsequence

    sequence s_release;
        (!master_summary_bit || poll_rd) && !(master_summary_bit && !prev_master_summary);
    endsequence

    AST_STATUS_SET: assert property (push |=> (standard_event_status & $past(ev_bits)) == $past(ev_bits))
        else $error("enabled event did not set its status bit");
    AST_EVSUM_SET: assert property (push && (ev_bits & sum_en) != 8'h00 && !wr |=> event_summary_bit)
        else $error("event summary bit not set");
    AST_MSGAV_SUMMARY: assert property (outq_not_empty && srq_en[`STB_MSG_AVAIL] |-> status_byte[`STB_SUMMARY])
        else $error("message available did not reach master summary");
    AST_SERVICE_SET: assert property (s_summary_rise |=> request_service_bit ##1
                                      (request_service_bit || $past(poll_rd) || !$past(master_summary_bit)))
        else $error("service request not raised on summary rise");
    AST_SERVICE_DROP: assert property (s_release |=> !request_service_bit)
        else $error("service request not withdrawn");
    AST_SERVICE_HOLD: assert property (request_service_bit && master_summary_bit && !poll_rd
                                       |=> request_service_bit)
        else $error("service request dropped early");
    AST_CONFLICT: assert property (conflict_pend && !ev_valid |-> push_entry.code == `CODE_CONFLICT
                                   && ev_bits_raw[`BIT_EXEC_ERR])
        else $error("conflict event has wrong code or bit");
    AST_NO_CONFLICT: assert property (!(msg_done && settings_conflict) && !conflict_pend |=> !conflict_pend)
        else $error("conflict raised outside message end");
    AST_EMPTY_READ: assert property (evt_rd && q_count == '0 && !push |=> hrdata == 32'h0000_0000
                                     && standard_event_status == $past(standard_event_status))
        else $error("empty queue read wrong");
    AST_ESR_CLEAR: assert property (esr_rd && !push |=> standard_event_status == 8'h00)
        else $error("status read did not clear register");
    AST_OVF_NOBIT: assert property (ev_valid && ev_code == `CODE_OVERFLOW |-> ev_bits_raw == 8'h00)
        else $error("overflow code set a status bit");
endmodule

// ### ahb_host.sv
// Bus controller model: single-word AHB-Lite master that polls status and reads events.
`timescale 1ns/1ps
`include "ser_cfg.svh"
module ahb_host (
    // Clock and reset
    input  wire logic  hclk,
    input  wire logic  hresetn,
    // AHB-Lite master
    output logic        hsel,
    output logic [31:0] haddr,
    output logic [1:0]  htrans,
    output logic        hwrite,
    output logic [2:0]  hsize,
    output logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = `HSIZE_WORD;
        hwdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= `HSIZE_WORD;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        // Released write data is inverted so a stale value can never pass for a fresh one.
        hwdata <= ~wd;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, a, d, unused);
    endtask

    // Reads one word from the register at the given offset.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0, d);
    endtask
endmodule

// ### tb_status_event_reporting.sv
// Self-checking testbench of the status and event reporting block.
`timescale 1ns/1ps
`include "ser_cfg.svh"
module tb_status_event_reporting
    import ser_pkg::*;
;
    localparam int DEPTH = 20;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        ev_valid;
    event_code_t ev_code;
    logic [7:0]  ev_detail;
    logic        msg_done;
    logic        settings_conflict;
    logic        outq_not_empty;
    logic        service_request;
    int          failures;
    int          num_checks;
    logic [31:0] seed;
    logic [31:0] d;
    logic [7:0]  mask;
    logic [7:0]  det;
    logic [7:0]  exp;
    event_code_t c;
    event_code_t tbl [21] = '{10'h064, 10'h0b8, 10'h0c8, 10'h0dd, 10'h116, 10'h12c, 10'h13b, 10'h15e,
                              10'h191, 10'h192, 10'h193, 10'h19a, 10'h1b8, 10'h1f4, 10'h21c, 10'h000,
                              10'h001, 10'h063, 10'h0b9, 10'h117, 10'h21d};

    status_event_reporting #(.QUEUE_DEPTH(DEPTH)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .ev_valid(ev_valid), .ev_code(ev_code), .ev_detail(ev_detail),
        .msg_done(msg_done), .settings_conflict(settings_conflict), .outq_not_empty(outq_not_empty),
        .service_request(service_request)
    );

    ahb_host host (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    function automatic logic [7:0] cls(input event_code_t k);
        logic [7:0] b;
        b = 8'h00;
        if (k >= `CODE_CMD_LO && k <= `CODE_CMD_HI) b[`BIT_CMD_ERR] = 1'b1;
        if (k >= `CODE_EXEC_LO && k <= `CODE_EXEC_HI) b[`BIT_EXEC_ERR] = 1'b1;
        if (k >= `CODE_DEV_LO && k <= `CODE_DEV_HI) b[`BIT_DEV_ERR] = 1'b1;
        if (k == `CODE_POWER_ON) b[`BIT_POWER_ON] = 1'b1;
        if (k == `CODE_OPC) b[`BIT_OPC] = 1'b1;
        if (k == `CODE_USER_REQ) b[`BIT_USER_REQ] = 1'b1;
        if (k >= `CODE_QUERY_LO && k <= `CODE_QUERY_HI) b[`BIT_QUERY_ERR] = 1'b1;
        if (k >= `CODE_WARN_LO && k <= `CODE_WARN_HI) b[`BIT_EXEC_ERR] = 1'b1;
        return b;
    endfunction

    // Event read word: code low, detail in [23:16], separator byte on top when a detail exists.
    function automatic logic [31:0] ent(input event_code_t k, input logic [7:0] t);
        return {(t != 8'h00) ? `SEMICOLON : 8'h00, t, 6'h00, k};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] expect_v);
        num_checks++;
        if (seen !== expect_v) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expect_v);
        end
    endtask

    task automatic ev(input event_code_t k, input logic [7:0] t);
        @(posedge hclk);
        ev_valid  <= 1'b1;
        ev_code   <= k;
        ev_detail <= t;
        @(posedge hclk);
        ev_valid  <= 1'b0;
    endtask

    task automatic msg(input logic cf);
        @(posedge hclk);
        msg_done          <= 1'b1;
        settings_conflict <= cf;
        @(posedge hclk);
        msg_done          <= 1'b0;
        settings_conflict <= 1'b0;
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial begin
        repeat (40000) @(posedge hclk);
        failures++;
        tally_and_finish();
    end

    initial begin
        hresetn = 1'b0; ev_valid = 1'b0; ev_code = 10'h000; ev_detail = 8'h00;
        msg_done = 1'b0; settings_conflict = 1'b0; outq_not_empty = 1'b0;
        failures = 0; num_checks = 0; seed = 32'h59;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        host.rd(`ADDR_DEV_EN, d); chk(d, {24'h0, `DEV_EN_RST});
        host.rd(`ADDR_SUM_EN, d); chk(d, {24'h0, `SUM_EN_RST});
        host.rd(`ADDR_SRQ_EN, d); chk(d, {24'h0, `SRQ_EN_RST});
        host.wr(`ADDR_EVT_STAT, 32'hff);
        host.rd(`ADDR_EVT_STAT, d); chk(d, 32'h0);
        host.wr(8'h20, 32'h5a);
        host.rd(8'h20, d); chk(d, 32'h0);
        host.rd(`ADDR_EVT_READ, d); chk(d, 32'h0);
        // Fixed code table with all enables on, then random codes behind random enable masks.
        for (int i = 0; i < 51; i++) begin
            seed = xs(seed); mask = (i < 21) ? 8'hff : seed[7:0];
            seed = xs(seed); c = (i < 21) ? tbl[i] : event_code_t'(seed % 32'h258);
            seed = xs(seed); det = seed[15:8];
            host.wr(`ADDR_DEV_EN, {24'h0, mask});
            host.rd(`ADDR_DEV_EN, d); chk(d, {24'h0, mask});
            ev(c, det);
            exp = cls(c) & mask;
            host.rd(`ADDR_EVT_READ, d); chk(d, (exp != 8'h00) ? 32'h1 : 32'h0);
            host.rd(`ADDR_EVT_STAT, d); chk(d, {24'h0, exp});
            if (exp != 8'h00) begin
                host.rd(`ADDR_EVT_READ, d); chk(d, ent(c, det));
            end
            host.rd(`ADDR_EVT_READ, d); chk(d, 32'h0);
        end
        host.wr(`ADDR_DEV_EN, 32'hff);
        // Only events summarised by a status read are handed out.
        ev(`CODE_USER_REQ, 8'h05);
        host.rd(`ADDR_EVT_STAT, d); chk(d, 32'h40);
        ev(`CODE_POWER_ON, 8'h00);
        host.rd(`ADDR_EVT_READ, d); chk(d, ent(`CODE_USER_REQ, 8'h05));
        host.rd(`ADDR_EVT_READ, d); chk(d, 32'h1);
        host.rd(`ADDR_EVT_STAT, d); chk(d, 32'h80);
        host.rd(`ADDR_EVT_READ, d); chk(d, ent(`CODE_POWER_ON, 8'h00));
        host.rd(`ADDR_EVT_READ, d); chk(d, 32'h0);
        // Summary, message available and service request.
        host.wr(`ADDR_SUM_EN, 32'h10);
        host.wr(`ADDR_SRQ_EN, 32'h20);
        ev(`CODE_CONFLICT, 8'h00);
        host.rd(`ADDR_STB, d); chk(d, 32'h60);
        chk({31'h0, service_request}, 32'h1);
        host.rd(`ADDR_POLL, d); chk(d, 32'h60);
        chk({31'h0, service_request}, 32'h0);
        host.rd(`ADDR_POLL, d); chk(d, 32'h20);
        host.rd(`ADDR_EVT_STAT, d); chk(d, 32'h10);
        host.rd(`ADDR_STB, d); chk(d, 32'h0);
        outq_not_empty <= 1'b1;
        host.rd(`ADDR_STB, d); chk(d, 32'h10);
        host.wr(`ADDR_SRQ_EN, 32'h10);
        host.rd(`ADDR_STB, d); chk(d, 32'h50);
        chk({31'h0, service_request}, 32'h1);
        outq_not_empty <= 1'b0;
        host.rd(`ADDR_STB, d); chk(d, 32'h0);
        chk({31'h0, service_request}, 32'h0);
        // Conflicts are judged only at the end of a message.
        settings_conflict <= 1'b1;
        repeat (3) @(posedge hclk);
        msg(1'b0);
        host.rd(`ADDR_EVT_STAT, d); chk(d, 32'h0);
        msg(1'b1);
        host.rd(`ADDR_EVT_STAT, d); chk(d, 32'h10);
        host.rd(`ADDR_EVT_READ, d); chk({22'h0, d[9:0]}, {22'h0, `CODE_CONFLICT});
        // Overfill the queue; the last slot turns into the overflow marker.
        for (int k = 0; k < DEPTH + 2; k++) begin
            ev(`CODE_OPC, 8'h00);
        end
        host.rd(`ADDR_EVT_CNT, d); chk({24'h0, d[7:0]}, DEPTH);
        host.rd(`ADDR_EVT_STAT, d); chk(d, 32'h1);
        for (int k = 0; k < DEPTH - 1; k++) begin
            host.rd(`ADDR_EVT_READ, d); chk(d, ent(`CODE_OPC, 8'h00));
        end
        host.rd(`ADDR_EVT_READ, d); chk({22'h0, d[9:0]}, {22'h0, `CODE_OVERFLOW});
        host.rd(`ADDR_EVT_READ, d); chk(d, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        tally_and_finish();
    end
endmodule
